/* hdl/srm_top.sv */
// Context B read mode control and pixel readout sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "srm_map.svh"
module srm_top
  import srm_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // Register port
  input  wire logic                   i_reg_we,
  input  wire logic                   i_reg_re,
  input  wire logic [7:0]             i_reg_addr,
  input  wire logic [15:0]            i_reg_wdata,
  output logic [15:0]                 o_reg_rdata,
  output logic                        o_reg_rvalid,
  // Settings held elsewhere in the sensor core
  input  wire logic                   i_context_select_bit,
  input  wire logic                   i_ctxa_low_power,
  input  wire logic                   i_ctxa_col_skip2,
  input  wire logic                   i_ctxa_row_skip2,
  input  wire logic                   i_sync_hold,
  input  wire logic                   i_show_bad_frames,
  input  wire logic [11:0]            i_row_start,
  input  wire logic [11:0]            i_col_start,
  input  wire logic [11:0]            i_row_size,
  input  wire logic [11:0]            i_col_size,
  input  wire logic [11:0]            i_hblank,
  input  wire logic [11:0]            i_vblank,
  // Pixel array
  output logic                        o_array_rd,
  output logic [11:0]                 o_row_addr,
  output logic [11:0]                 o_col_addr,
  input  wire logic [`SRM_PIX_W-1:0]  i_array_data,
  // Pixel stream
  output logic                        o_pix_valid,
  input  wire logic                   i_out_ready,
  output logic [`SRM_PIX_W-1:0]       o_pix_data,
  output logic                        o_line_valid_out,
  output logic                        o_frame_valid_out,
  output logic                        o_pix_clk_half
);
  localparam int FW = `SRM_PIX_W + 2;

  // Live register and its frame-synchronous copy.
  logic [15:0]  rmode;
  logic [15:0]  shadow;
  srm_ctr_t     sh_row_start;
  srm_ctr_t     sh_col_start;
  srm_ctr_t     sh_row_size;
  srm_ctr_t     sh_col_size;
  srm_ctr_t     sh_hblank;
  srm_ctr_t     sh_vblank;
  logic         init_pend;
  logic         bad_frame;

  // Scan position.
  srm_ctr_t     h_cnt;
  srm_ctr_t     v_cnt;
  srm_phase_t   phase;
  logic         lp_phase;
  logic         p_lv;
  logic         p_fv;

  // FIFO wiring.
  logic                        f_in_ready;
  logic                        f_out_valid;
  logic [FW-1:0]               f_out_data;
  logic [`SRM_FIFO_CNT_W-1:0]  f_count;
  logic                        out_load;

  // Combinational decode.
  logic      low_power;
  logic      col_skip2;
  logic      row_skip2;
  logic      oversize;
  srm_ctr_t  rows_ext;
  srm_ctr_t  cols_ext;
  srm_ctr_t  line_len;
  srm_ctr_t  frame_rows;
  logic      row_border;
  logic      col_border;
  srm_ctr_t  row_inner;
  srm_ctr_t  col_inner;
  logic      keep_row;
  logic      keep_col;
  logic      in_cols;
  logic      skip_row_now;
  logic      step;
  logic      push;
  logic      line_end;
  logic      frame_end;
  logic      shadow_load;
  logic      settings_changed;
  logic      lv_norm;
  logic      lv_cont;
  logic      fv_cur;
  logic      next_lv;
  logic      next_fv;

  // Keeps two of every four (2x) or two of every eight (4x) offsets.
  function automatic logic skip_keep(input srm_ctr_t off, input logic s2, input logic s4);
    logic k;
    k = 1'b1;
    if (s4) begin
      k = (off[2:1] == 2'b00);
    end else if (s2) begin
      k = (off[1] == 1'b0);
    end
    return k;
  endfunction

  // Register port.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rmode <= `SRM_RMODE_B_RST;
    end else if (i_reg_we && (i_reg_addr == `SRM_RMODE_B_OFS)) begin
      rmode <= i_reg_wdata & `SRM_RMODE_B_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_re;
      if (i_reg_re) begin
        o_reg_rdata <= (i_reg_addr == `SRM_RMODE_B_OFS) ? rmode : 16'h0000;
      end
    end
  end

  // Context selection of the power and 2x skip fields.
  assign low_power = i_context_select_bit ? shadow[`SRM_B_LOW_PWR]   : i_ctxa_low_power;
  assign col_skip2 = i_context_select_bit ? shadow[`SRM_B_COL_SKIP2] : i_ctxa_col_skip2;
  assign row_skip2 = i_context_select_bit ? shadow[`SRM_B_ROW_SKIP2] : i_ctxa_row_skip2;

  // Frame geometry, grown by the border when oversize is set.
  assign oversize   = shadow[`SRM_B_OVERSIZE];
  assign rows_ext   = oversize ? srm_ctr_t'(sh_row_size + `SRM_BORDER_ADD) : sh_row_size;
  assign cols_ext   = oversize ? srm_ctr_t'(sh_col_size + `SRM_BORDER_ADD) : sh_col_size;
  assign line_len   = srm_ctr_t'(cols_ext + sh_hblank);
  assign frame_rows = srm_ctr_t'(rows_ext + sh_vblank);

  // Border positions do not depend on skip or mirror.
  assign row_border = oversize && ((v_cnt < `SRM_BORDER_W) ||
                      (v_cnt >= srm_ctr_t'(sh_row_size + `SRM_BORDER_W)));
  assign col_border = oversize && ((h_cnt < `SRM_BORDER_W) ||
                      (h_cnt >= srm_ctr_t'(sh_col_size + `SRM_BORDER_W)));
  assign row_inner  = oversize ? srm_ctr_t'(v_cnt - `SRM_BORDER_W) : v_cnt;
  assign col_inner  = oversize ? srm_ctr_t'(h_cnt - `SRM_BORDER_W) : h_cnt;

  assign keep_row = row_border ||
                    skip_keep(row_inner, row_skip2, shadow[`SRM_B_ROW_SKIP4]);
  assign keep_col = col_border ||
                    skip_keep(col_inner, col_skip2, shadow[`SRM_B_COL_SKIP4]);
  assign in_cols  = (h_cnt < cols_ext);

  // Stepping: half rate in low power, and only with room for the word in flight.
  assign step = !init_pend && f_in_ready &&
                ({1'b0, f_count} + {4'h0, o_array_rd} < 5'(`SRM_FIFO_DEPTH)) &&
                (!low_power || lp_phase);
  assign skip_row_now = (phase == SRM_ACTIVE) && !keep_row;
  assign line_end     = skip_row_now || (h_cnt == srm_ctr_t'(line_len - 1'b1));
  assign frame_end    = line_end && (v_cnt == srm_ctr_t'(frame_rows - 1'b1));
  assign push         = step && !skip_row_now && !(in_cols && !keep_col);
  assign shadow_load  = init_pend || (step && frame_end && !i_sync_hold);

  assign settings_changed = ((rmode & `SRM_SYNC_MASK) != (shadow & `SRM_SYNC_MASK)) ||
                            (i_row_start != sh_row_start) || (i_col_start != sh_col_start) ||
                            (i_row_size != sh_row_size) || (i_col_size != sh_col_size) ||
                            (i_hblank != sh_hblank);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lp_phase <= 1'b0;
    end else begin
      lp_phase <= low_power ? !lp_phase : 1'b0;
    end
  end

  // Double-buffered settings, loaded only at a frame boundary.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      init_pend <= 1'b1;
      shadow <= `SRM_RMODE_B_RST & `SRM_SYNC_MASK;
      sh_row_start <= '0;
      sh_col_start <= '0;
      sh_row_size <= '0;
      sh_col_size <= '0;
      sh_hblank <= '0;
      sh_vblank <= '0;
    end else begin
      init_pend <= 1'b0;
      if (shadow_load) begin
        shadow <= rmode & `SRM_SYNC_MASK;
        sh_row_start <= i_row_start;
        sh_col_start <= i_col_start;
        sh_row_size <= i_row_size;
        sh_col_size <= i_col_size;
        sh_hblank <= i_hblank;
        sh_vblank <= i_vblank;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bad_frame <= 1'b0;
    end else if (step && frame_end) begin
      bad_frame <= !i_sync_hold && !init_pend && settings_changed;
    end
  end

  // Scan counters.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      h_cnt <= '0;
      v_cnt <= '0;
      phase <= SRM_ACTIVE;
    end else if (step) begin
      if (line_end) begin
        h_cnt <= '0;
        if (frame_end) begin
          v_cnt <= '0;
          phase <= SRM_ACTIVE;
        end else begin
          v_cnt <= srm_ctr_t'(v_cnt + 1'b1);
          phase <= (srm_ctr_t'(v_cnt + 1'b1) >= rows_ext) ? SRM_VBLANK : SRM_ACTIVE;
        end
      end else begin
        h_cnt <= srm_ctr_t'(h_cnt + 1'b1);
      end
    end
  end

  // Line and frame valid for the current position.
  always_comb begin
    fv_cur  = (phase == SRM_ACTIVE);
    lv_cont = in_cols && keep_col;
    lv_norm = fv_cur && in_cols && keep_col &&
              (!(row_border || col_border) || rmode[`SRM_B_SHOW_BRD]);
    if (rmode[`SRM_B_CONT_LV]) begin
      next_lv = lv_cont;
    end else if (rmode[`SRM_B_XOR_LV]) begin
      next_lv = lv_cont ^ fv_cur;
    end else begin
      next_lv = lv_norm;
    end
    next_fv = fv_cur;
    if (bad_frame && !i_show_bad_frames) begin
      next_lv = 1'b0;
      next_fv = 1'b0;
    end
  end

  // Array address, with mirroring per axis.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_array_rd <= 1'b0;
      o_row_addr <= 12'h000;
      o_col_addr <= 12'h000;
      p_lv <= 1'b0;
      p_fv <= 1'b0;
    end else begin
      o_array_rd <= push;
      if (push) begin
        o_row_addr <= shadow[`SRM_B_MIRROR_ROW] ?
                      srm_ctr_t'(sh_row_start + sh_row_size - row_inner) :
                      srm_ctr_t'(sh_row_start + row_inner);
        o_col_addr <= shadow[`SRM_B_MIRROR_COL] ?
                      srm_ctr_t'(sh_col_start + sh_col_size - col_inner) :
                      srm_ctr_t'(sh_col_start + col_inner);
        p_lv <= next_lv;
        p_fv <= next_fv;
      end
    end
  end

  srm_fifo #(
    .WIDTH (FW),
    .DEPTH (`SRM_FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (o_array_rd),
    .o_in_ready  (f_in_ready),
    .i_in_data   ({p_fv, p_lv, i_array_data}),
    .o_out_valid (f_out_valid),
    .i_out_ready (out_load),
    .o_out_data  (f_out_data),
    .o_count     (f_count)
  );

  // Output register stage after the FIFO.
  assign out_load = !o_pix_valid || i_out_ready;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pix_valid <= 1'b0;
      o_pix_data <= '0;
      o_line_valid_out <= 1'b0;
      o_frame_valid_out <= 1'b0;
    end else if (out_load) begin
      o_pix_valid <= f_out_valid;
      if (f_out_valid) begin
        o_frame_valid_out <= f_out_data[FW-1];
        o_line_valid_out <= f_out_data[FW-2];
        o_pix_data <= f_out_data[`SRM_PIX_W-1:0];
      end
    end
  end

  // The pixel output clock follows the readout rate without software help.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pix_clk_half <= 1'b0;
    end else begin
      o_pix_clk_half <= low_power;
    end
  end
endmodule // srm_top
`default_nettype wire

/* hdl/srm_map.svh */
// Constants of the context B read mode block: offsets, field positions, resets and sizes.
//
// Overview of operation
// - Bit 15 set: line valid is continuous XOR frame.
// - XOR clear follows bit 9; continuous overrides XOR.
// - Bit 14 keeps line pulses through vertical blanking.
// - Context B power/2x skip only when selected.
// - Bit 10 selects low power, half-rate readout.
// - Low power adjusts pixel output clock automatically.
// - Bit 8 adds 4-pixel border in all modes.
// - Border grows frame by 8 rows, 8 columns.
// - Bit 9 marks border active or blanking; resets 1.
// - Bit 9 ignored when border is off.
// - Column 4x skip reads two, skips six.
// - Row 4x skip reads two rows, skips six.
// - Context B column 2x reads two, skips two.
// - Context B row 2x reads two, skips two.
// - Column mirror reads start+size down to start+1.
// - Row mirror reads start+size down to start+1.
// - Synced settings apply at frame boundary unless held.
// - First frame after synced non-vblank change is bad, suppressed.
`ifndef SRM_MAP_SVH
`define SRM_MAP_SVH

`define SRM_RMODE_B_OFS   8'h20
`define SRM_RMODE_B_RST   16'h0300
`define SRM_RMODE_B_MASK  16'hc7bf
`define SRM_SYNC_MASK     16'h05bf

`define SRM_B_XOR_LV      15
`define SRM_B_CONT_LV     14
`define SRM_B_LOW_PWR     10
`define SRM_B_SHOW_BRD    9
`define SRM_B_OVERSIZE    8
`define SRM_B_COL_SKIP4   5
`define SRM_B_ROW_SKIP4   4
`define SRM_B_COL_SKIP2   3
`define SRM_B_ROW_SKIP2   2
`define SRM_B_MIRROR_COL  1
`define SRM_B_MIRROR_ROW  0

`define SRM_BORDER_W      12'd4
`define SRM_BORDER_ADD    12'd8
`define SRM_PIX_W         10
`define SRM_FIFO_DEPTH    8
`define SRM_FIFO_CNT_W    4

`endif

/* hdl/srm_pkg.sv */
// Types shared by the context B read mode block.
package srm_pkg;
  typedef logic [11:0] srm_ctr_t;
  typedef enum {SRM_ACTIVE, SRM_VBLANK} srm_phase_t;
endpackage

/* hdl/srm_fifo.sv */
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module srm_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  // Fill side
  input  wire logic                       i_in_valid,
  output logic                            o_in_ready,
  input  wire logic [WIDTH-1:0]           i_in_data,
  // Drain side
  output logic                            o_out_valid,
  input  wire logic                       i_out_ready,
  output logic [WIDTH-1:0]                o_out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0]      o_count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             do_wr;
  logic             do_rd;

  assign o_in_ready  = (o_count != CW'(DEPTH));
  assign o_out_valid = (o_count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign do_wr       = i_in_valid && o_in_ready;
  assign do_rd       = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      o_count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      if (do_wr && !do_rd) begin
        o_count <= CW'(o_count + 1'b1);
      end else if (do_rd && !do_wr) begin
        o_count <= CW'(o_count - 1'b1);
      end
    end
  end
endmodule // srm_fifo
`default_nettype wire

/* test/srm_top_chk.sv */
// Port-level assertions for the context B read mode block.
`timescale 1ns/1ps
`default_nettype none
`include "srm_map.svh"
module srm_top_chk (
  input wire logic                  i_clk,
  input wire logic                  i_rst,
  input wire logic                  i_reg_we,
  input wire logic                  i_reg_re,
  input wire logic [7:0]            i_reg_addr,
  input wire logic [15:0]           i_reg_wdata,
  input wire logic [15:0]           o_reg_rdata,
  input wire logic                  o_reg_rvalid,
  input wire logic                  o_array_rd,
  input wire logic                  o_pix_valid,
  input wire logic                  i_out_ready,
  input wire logic [`SRM_PIX_W-1:0] o_pix_data,
  input wire logic                  o_line_valid_out,
  input wire logic                  o_frame_valid_out,
  input wire logic                  o_pix_clk_half
);
  logic [15:0] rmode;
  logic [5:0]  settle;
  always_ff @(posedge i_clk) begin
    if (i_rst)
      rmode <= 16'h0300;
    else if (i_reg_we && i_reg_addr == 8'h20)
      rmode <= i_reg_wdata & 16'hc7bf;
  end
  // Words already buffered may predate a write, so wait until they have drained.
  always_ff @(posedge i_clk) begin
    if (i_rst || i_reg_we)
      settle <= 6'h00;
    else if (settle != 6'h3f)
      settle <= settle + 6'h01;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_stall;
    o_pix_valid && !i_out_ready;
  endsequence
  sequence s_vblank_word;
    settle == 6'h3f && o_pix_valid && !o_frame_valid_out && !rmode[14] && !rmode[15];
  endsequence
  // The rate indicator lags the rate by one cycle, so the read that follows a
  // read is judged by the indicator sampled with it.
  sequence s_slow_step;
    o_pix_clk_half && o_array_rd ##1 o_pix_clk_half;
  endsequence
  AST_RVALID: assert property (i_reg_re |=> o_reg_rvalid) else $error("read not answered");
  AST_RVALID_ONE: assert property (!i_reg_re |=> !o_reg_rvalid) else $error("stray rvalid");
  AST_UNMAPPED: assert property (i_reg_re && i_reg_addr != 8'h20
    |=> o_reg_rdata == 16'h0000) else $error("unmapped read not zero");
  AST_RESERVED: assert property (o_reg_rvalid |-> (o_reg_rdata & 16'h3840) == 16'h0000)
    else $error("reserved bits set");
  AST_HOLD: assert property (s_stall |=> o_pix_valid && $stable(o_pix_data)
    && $stable(o_line_valid_out) && $stable(o_frame_valid_out)) else $error("word changed");
  AST_LV_VBLANK: assert property (s_vblank_word |-> !o_line_valid_out)
    else $error("line valid in blanking");
  AST_HALF_RATE: assert property (s_slow_step |-> !o_array_rd) else $error("full rate read");
  AST_RESET: assert property (disable iff (1'b0) i_rst |=> !o_pix_valid && !o_array_rd
    && !o_reg_rvalid && !o_frame_valid_out && !o_pix_clk_half) else $error("reset value");
endmodule // srm_top_chk
bind srm_top srm_top_chk u_chk (.i_clk, .i_rst, .i_reg_we, .i_reg_re, .i_reg_addr, .i_reg_wdata,
  .o_reg_rdata, .o_reg_rvalid, .o_array_rd, .o_pix_valid, .i_out_ready, .o_pix_data,
  .o_line_valid_out, .o_frame_valid_out, .o_pix_clk_half);
`default_nettype wire

/* test/srm_sink_model.sv */
// Stream sink standing for the image pipeline, with tallies per frame period.
`timescale 1ns/1ps
`default_nettype none
module srm_sink_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_slow,
  input  wire logic        i_valid,
  input  wire logic        i_lv,
  input  wire logic        i_fv,
  input  wire logic [9:0]  i_data,
  output logic             o_ready,
  output logic [15:0]      o_falls,
  output logic [15:0]      o_lv_last,
  output logic [9:0]       o_first,
  output logic [31:0]      o_stamp
);
  logic [31:0] cyc;
  logic [15:0] cnt;
  logic        fv_q;
  logic        take;
  logic        fall;
  // Slow mode takes one word in four, so the scan backs up behind the buffer.
  assign o_ready = !i_slow || cyc[1:0] == 2'b00;
  assign take = i_valid && o_ready;
  assign fall = take && fv_q && !i_fv;
  always_ff @(posedge i_clk) begin
    cyc <= i_rst ? 32'h0 : cyc + 32'h1;
    if (i_rst) begin
      cnt <= 16'h0;
      fv_q <= 1'b0;
      o_falls <= 16'h0;
    end else if (take) begin
      fv_q <= i_fv;
      cnt <= fall ? {15'h0, i_lv} : cnt + {15'h0, i_lv};
      if (i_lv && (fall || cnt == 16'h0))
        o_first <= i_data;
      if (fall) begin
        o_falls <= o_falls + 16'h1;
        o_lv_last <= cnt;
        o_stamp <= cyc;
      end
    end
  end
endmodule // srm_sink_model
`default_nettype wire

/* test/sensor_read_mode_ctx_b_tb.sv */
// Self-checking bench for the context B read mode block.
`timescale 1ns/1ps
`default_nettype none
module sensor_read_mode_ctx_b_tb;
  logic        i_clk, i_rst, we, re, sel, ca, hold, bad, slow, rvalid, rd, pv, rdy, lv, fv, half;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, falls, lv_last;
  logic [11:0] col_start, row_a, col_a;
  logic [9:0]  adata, pdata, first;
  logic [31:0] stamp;
  int          n_mismatch, total_checks, cyc;
  assign adata = {row_a[4:0], col_a[4:0]};
  srm_top dut (.i_clk, .i_rst, .i_reg_we(we), .i_reg_re(re), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_context_select_bit(sel), .i_ctxa_low_power(ca), .i_ctxa_col_skip2(ca),
    .i_ctxa_row_skip2(ca), .i_sync_hold(hold), .i_show_bad_frames(bad),
    .i_row_start(12'h010), .i_col_start(col_start), .i_row_size(12'h004),
    .i_col_size(12'h008), .i_hblank(12'h002), .i_vblank(12'h002), .o_array_rd(rd),
    .o_row_addr(row_a), .o_col_addr(col_a), .i_array_data(adata), .o_pix_valid(pv),
    .i_out_ready(rdy), .o_pix_data(pdata), .o_line_valid_out(lv), .o_frame_valid_out(fv),
    .o_pix_clk_half(half));
  srm_sink_model u_sink (.i_clk, .i_rst, .i_slow(slow), .i_valid(pv), .i_lv(lv), .i_fv(fv),
    .i_data(pdata), .o_ready(rdy), .o_falls(falls), .o_lv_last(lv_last), .o_first(first),
    .o_stamp(stamp));
  always #5 i_clk = ~i_clk;
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    we <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    re <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    re <= 1'b0;
    #1;
    check(rvalid, 1'b1);
    check(rdata, exp);
  endtask
  task automatic wait_falls(input int n);
    logic [15:0] target;
    int          k;
    target = falls + 16'(n);
    k = 0;
    while (falls !== target && k < 4000 * n) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    check(falls, target);
  endtask
  // Control nibble: context select, sync hold, slow sink, context A fields.
  task automatic run_mode(input logic [15:0] m, input logic [3:0] c, input logic [15:0] n,
                          input logic [9:0] f, input logic h);
    @(posedge i_clk);
    {sel, hold, slow, ca} <= c;
    reg_wr(8'h20, m);
    wait_falls(3);
    check(lv_last, n);
    if (f !== 10'h3ff)
      check(first, f);
    check(half, h);
  endtask
  task automatic test_regs;
    reg_rd(8'h20, 16'h0300);
    reg_wr(8'h20, 16'hffff);
    reg_wr(8'h21, 16'h0000);
    reg_rd(8'h20, 16'hc7bf);
    reg_rd(8'h21, 16'h0000);
  endtask
  task automatic test_skip;
    run_mode(16'h0000, 4'h8, 16'd32, 10'h200, 1'b0);
    run_mode(16'h0008, 4'h8, 16'd16, 10'h200, 1'b0);
    run_mode(16'h0004, 4'h8, 16'd16, 10'h200, 1'b0);
    run_mode(16'h0020, 4'h8, 16'd8, 10'h200, 1'b0);
    run_mode(16'h0010, 4'h8, 16'd16, 10'h200, 1'b0);
  endtask
  task automatic test_border;
    run_mode(16'h0100, 4'h8, 16'd32, 10'h200, 1'b0);
    run_mode(16'h0300, 4'h8, 16'd192, 10'h19c, 1'b0);
    run_mode(16'h0200, 4'h8, 16'd32, 10'h200, 1'b0);
  endtask
  task automatic test_mirror;
    run_mode(16'h0003, 4'h8, 16'd32, 10'h288, 1'b0);
    run_mode(16'h0001, 4'h8, 16'd32, 10'h280, 1'b0);
    @(posedge i_clk);
    col_start <= 12'h024;
    run_mode(16'h0002, 4'h8, 16'd32, 10'h20c, 1'b0);
    @(posedge i_clk);
    col_start <= 12'h020;
  endtask
  task automatic test_lv;
    run_mode(16'h4000, 4'h8, 16'd48, 10'h3ff, 1'b0);
    run_mode(16'hc000, 4'h8, 16'd48, 10'h3ff, 1'b0);
    run_mode(16'h8000, 4'h8, 16'd24, 10'h3ff, 1'b0);
  endtask
  task automatic test_context;
    run_mode(16'h0400, 4'h8, 16'd32, 10'h200, 1'b1);
    run_mode(16'h0400, 4'h0, 16'd32, 10'h200, 1'b0);
    run_mode(16'h0000, 4'h1, 16'd8, 10'h200, 1'b1);
  endtask
  task automatic test_hold_stall;
    run_mode(16'h0000, 4'h8, 16'd32, 10'h200, 1'b0);
    run_mode(16'h0004, 4'hc, 16'd32, 10'h200, 1'b0);
    run_mode(16'h0004, 4'h8, 16'd16, 10'h200, 1'b0);
    run_mode(16'h0000, 4'ha, 16'd32, 10'h200, 1'b0);
  endtask
  task automatic test_bad_frame;
    logic [31:0] s0;
    run_mode(16'h0000, 4'h8, 16'd32, 10'h200, 1'b0);
    s0 = stamp;
    reg_wr(8'h20, 16'h0002);
    wait_falls(1);
    check(stamp - s0, 32'd120);
    @(posedge i_clk);
    bad <= 1'b1;
    wait_falls(1);
    s0 = stamp;
    reg_wr(8'h20, 16'h0000);
    wait_falls(1);
    check(stamp - s0, 32'd60);
  endtask
  initial begin
    {i_clk, we, re, sel, ca, hold, bad, slow} = '0;
    i_rst = 1'b1;
    addr = 8'h00;
    wdata = 16'h0000;
    col_start = 12'h020;
    cyc = 0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    test_regs();
    test_skip();
    test_border();
    test_mirror();
    test_lv();
    test_context();
    test_hold_stall();
    test_bad_frame();
    test_done();
  end
endmodule // sensor_read_mode_ctx_b_tb
`default_nettype wire
